/* rtl/divider_pkg.sv */
/*
  Shared constants and types of the phase-matched clock divider: register
  map, field positions, reset values, bus response codes and the states of
  the release sequencer. Assumes a 32-bit AXI4-Lite register bus.
*/
package divider_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // Control register fields.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_SEL_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields.
  localparam int STAT_FWD_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_LIVE_BIT = 2;
  localparam int STAT_CNT_LSB = 4;
  localparam int STAT_OUT_LSB = 8;
  localparam int STAT_UNHOLD_BIT = 16;

  // Phase counter restarts here so the first primary edge reads as zero.
  localparam logic [2:0] PHASE_RESET = 3'h7;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_OFF,
    ST_SYNC,
    ST_HOLD,
    ST_RUN
  } div_state_type;

endpackage

/* rtl/regs_if.sv */
/*
  Carrier between the register slave and the divider core: control bits
  out of the register file, status word back into it. Assumes both ends
  sit on the same clock.
*/
`timescale 1ns/10ps
interface regs_if;
  logic mode;
  logic hold_en;
  logic sync_sel;
  logic [31:0] status;

  modport bus (
    output mode,
    output hold_en,
    output sync_sel,
    input status
  );

  modport core (
    input mode,
    input hold_en,
    input sync_sel,
    output status
  );
endinterface

/* rtl/axi_lite_regs.sv */
/*
  AXI4-Lite slave holding the control register and presenting the status
  word. Assumes a master that keeps at most one write and one read in
  flight and holds valid and payload until taken.
*/
`timescale 1ns/10ps
module axi_lite_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  regs_if.bus rif
);

  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] ctrl_q;

  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire do_write = ~awready & ~wready & ~bvalid;
  wire b_done = bvalid & bready;
  wire ar_take = arvalid & arready;
  wire r_done = rvalid & rready;
  wire wr_ctrl = aw_addr_q[7:2] == divider_pkg::CTRL_OFFSET[7:2];
  wire wr_stat = aw_addr_q[7:2] == divider_pkg::STATUS_OFFSET[7:2];
  wire rd_ctrl = araddr[7:2] == divider_pkg::CTRL_OFFSET[7:2];
  wire rd_stat = araddr[7:2] == divider_pkg::STATUS_OFFSET[7:2];
  wire [31:0] ctrl_new = {29'h0, w_data_q[2:0]};

  assign rif.mode = ctrl_q[divider_pkg::CTRL_MODE_BIT];
  assign rif.hold_en = ctrl_q[divider_pkg::CTRL_HOLD_BIT];
  assign rif.sync_sel = ctrl_q[divider_pkg::CTRL_SEL_BIT];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end else if (b_done) begin
        awready <= 1'b1;
      end
      if (w_take) begin
        wready <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (b_done) begin
        wready <= 1'b1;
      end
    end
  end

  // The status word is read-only; a write to it is accepted and dropped.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= divider_pkg::RESP_OKAY;
      ctrl_q <= divider_pkg::CTRL_RESET;
    end else if (do_write) begin
      bvalid <= 1'b1;
      if (wr_ctrl) begin
        bresp <= divider_pkg::RESP_OKAY;
        if (w_strb_q[0]) begin
          ctrl_q <= ctrl_new;
        end
      end else if (wr_stat) begin
        bresp <= divider_pkg::RESP_OKAY;
      end else begin
        bresp <= divider_pkg::RESP_SLVERR;
      end
    end else if (b_done) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= divider_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      if (rd_ctrl) begin
        rdata <= ctrl_q;
        rresp <= divider_pkg::RESP_OKAY;
      end else if (rd_stat) begin
        rdata <= rif.status;
        rresp <= divider_pkg::RESP_OKAY;
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= divider_pkg::RESP_SLVERR;
      end
    end else if (r_done) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

endmodule

/* rtl/phase_matched_divider.sv */
/*
  Phase-matched clock divider in legacy mode. Samples the primary and
  secondary reference clocks on ref_clk, forwards the secondary one and
  derives undivided, /2, /4 and /8 outputs from the primary one. Assumes
  both reference clocks are slower than a quarter of the ref_clk rate and
  that
  software programs the control register over AXI4-Lite.
*/
// The register addresses and the AXI4-Lite register port were left to the implementer.
// Notes on behaviour
// - Divider acts only when mode bit set
// - Exactly two reference clock inputs exist
// - Primary clock sources all divided outputs
// - Secondary clock is forwarded, never divided
// - Reset forces every output low at once
// - Outputs toggle only after synchronised release
// - Release syncs to primary or secondary clock
// - Hold keeps primary outputs low until unhold
// - Unhold starts primary outputs at primary edge
// - Output zero secondary, one to four primary
// - Output zero follows secondary at its rate
`timescale 1ns/10ps
module phase_matched_divider (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Reference clocks and release pin
  input wire logic primary_ref_clock,
  input wire logic secondary_ref_clock,
  input wire logic output_unhold_input,
  // Clock outputs
  output logic output_zero,
  output logic output_one,
  output logic output_two,
  output logic output_three,
  output logic output_four,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  regs_if rif ();

  axi_lite_regs u_regs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rif(rif)
  );

  // Index 0 primary, 1 secondary, 2 unhold pin. Only two clocks exist.
  wire [2:0] pin_raw = {output_unhold_input, secondary_ref_clock,
                        primary_ref_clock};
  wire [2:0] sync2_q;
  logic [1:0] clk_dly_q;

  // Two flops per pin; the first stage feeds nothing but the second.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      logic meta_q;
      logic sync_q;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pin_raw[gi];
          sync_q <= meta_q;
        end
      end
      assign sync2_q[gi] = sync_q;
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_dly_q <= 2'h0;
    end else begin
      clk_dly_q <= sync2_q[1:0];
    end
  end

  wire prim_lvl = sync2_q[0];
  wire sec_lvl = sync2_q[1];
  wire unhold_lvl = sync2_q[2];
  wire prim_rise = sync2_q[0] & ~clk_dly_q[0];
  wire sec_rise = sync2_q[1] & ~clk_dly_q[1];
  // Release edge comes from the clock that software picked.
  wire sel_rise = rif.sync_sel ? sec_rise : prim_rise;
  wire hold_now = rif.hold_en & ~unhold_lvl;

  divider_pkg::div_state_type st_q;
  divider_pkg::div_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (!rif.mode) begin
      st_d = divider_pkg::ST_OFF;
    end else begin
      case (st_q)
        divider_pkg::ST_OFF: begin
          st_d = divider_pkg::ST_SYNC;
        end
        divider_pkg::ST_SYNC: begin
          if (sel_rise) begin
            st_d = hold_now ? divider_pkg::ST_HOLD : divider_pkg::ST_RUN;
          end
        end
        divider_pkg::ST_HOLD: begin
          if (!hold_now) begin
            st_d = divider_pkg::ST_RUN;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end
  end

  logic live_q;
  logic [2:0] phase_q;
  wire run_d = st_d == divider_pkg::ST_RUN;
  // Primary outputs start only on a primary rising edge.
  wire live_d = run_d & (live_q | prim_rise);
  wire fwd_d = run_d | (st_d == divider_pkg::ST_HOLD);
  wire [2:0] phase_inc = phase_q + 3'h1;
  wire [2:0] phase_d = !live_d ? divider_pkg::PHASE_RESET :
                       prim_rise ? phase_inc : phase_q;
  // Phase zero is a common rising edge of all divided outputs.
  wire div2_d = live_d & ~phase_d[0];
  wire div4_d = live_d & ~phase_d[1];
  wire div8_d = live_d & ~phase_d[2];
  wire undiv_d = live_d & prim_lvl;
  wire fwd_out_d = fwd_d & sec_lvl;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= divider_pkg::ST_OFF;
      live_q <= 1'b0;
      phase_q <= divider_pkg::PHASE_RESET;
    end else begin
      st_q <= st_d;
      live_q <= live_d;
      phase_q <= phase_d;
    end
  end

  // Asynchronous clear drops every clock output without any clock edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_zero <= 1'b0;
      output_one <= 1'b0;
      output_two <= 1'b0;
      output_three <= 1'b0;
      output_four <= 1'b0;
    end else begin
      output_zero <= fwd_out_d;
      output_one <= undiv_d;
      output_two <= div2_d;
      output_three <= div4_d;
      output_four <= div8_d;
    end
  end

  wire [4:0] outs = {output_four, output_three, output_two, output_one,
                     output_zero};

  always_comb begin
    rif.status = 32'h0000_0000;
    rif.status[divider_pkg::STAT_FWD_BIT] = fwd_d;
    rif.status[divider_pkg::STAT_HOLD_BIT] = st_q == divider_pkg::ST_HOLD;
    rif.status[divider_pkg::STAT_LIVE_BIT] = live_q;
    rif.status[divider_pkg::STAT_CNT_LSB +: 3] = phase_q;
    rif.status[divider_pkg::STAT_OUT_LSB +: 5] = outs;
    rif.status[divider_pkg::STAT_UNHOLD_BIT] = unhold_lvl;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_mode_off_quiet;
    !rif.mode |=> outs == 5'h00;
  endproperty
  a_mode_off_quiet: assert property (p_mode_off_quiet)
    else $error("outputs active while divider mode is off");

  property p_reset_exit_low;
    $rose(rst_n) |-> outs == 5'h00;
  endproperty
  a_reset_exit_low: assert property (p_reset_exit_low)
    else $error("output high at reset release");

  property p_quiet_before_release;
    st_q == divider_pkg::ST_SYNC |-> outs == 5'h00;
  endproperty
  a_quiet_before_release: assert property (p_quiet_before_release)
    else $error("output toggled before synchronised release");

  property p_release_on_selected;
    (st_q == divider_pkg::ST_SYNC && rif.mode && !sel_rise)
      |=> st_q == divider_pkg::ST_SYNC;
  endproperty
  a_release_on_selected: assert property (p_release_on_selected)
    else $error("release taken without edge of selected clock");

  property p_hold_quiet;
    st_q == divider_pkg::ST_HOLD |-> outs[4:1] == 4'h0;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("primary output active while held");

  property p_start_on_primary_edge;
    $rose(live_q) |-> $past(prim_rise) && output_one && output_four;
  endproperty
  a_start_on_primary_edge: assert property (p_start_on_primary_edge)
    else $error("primary outputs started off a primary edge");

  property p_forward_secondary;
    fwd_d |=> output_zero == $past(sec_lvl);
  endproperty
  a_forward_secondary: assert property (p_forward_secondary)
    else $error("output zero does not follow secondary clock");

  property p_undivided_primary;
    live_d |=> output_one == $past(prim_lvl);
  endproperty
  a_undivided_primary: assert property (p_undivided_primary)
    else $error("output one does not follow primary clock");

  property p_edges_aligned;
    $rose(output_four) |-> output_three && output_two && output_one;
  endproperty
  a_edges_aligned: assert property (p_edges_aligned)
    else $error("eighth-rate rise not aligned with other outputs");

  property p_half_toggles;
    (live_d && live_q && prim_rise) |=> output_two != $past(output_two);
  endproperty
  a_half_toggles: assert property (p_half_toggles)
    else $error("half-rate output missed a primary edge");

  property p_cov_hold_to_run;
    st_q == divider_pkg::ST_HOLD ##1 st_q == divider_pkg::ST_RUN;
  endproperty
  c_hold_to_run: cover property (p_cov_hold_to_run);

  property p_cov_eighth_rise;
    $rose(output_four);
  endproperty
  c_eighth_rise: cover property (p_cov_eighth_rise);

  property p_cov_secondary_release;
    rif.sync_sel && st_q == divider_pkg::ST_SYNC ##1
      st_q != divider_pkg::ST_SYNC;
  endproperty
  c_secondary_release: cover property (p_cov_secondary_release);

endmodule

/* tb/ref_clock_source.sv */
/*
  Fabric-side source of the primary and secondary reference clocks.
  Assumes the bench sets both half periods in 100 ns ref_clk cycles.
*/
`timescale 1ns/10ps
module ref_clock_source (
  // Half periods
  input wire logic [3:0] half_a,
  input wire logic [3:0] half_b,
  // Reference clocks
  output logic primary_ref_clock,
  output logic secondary_ref_clock
);
  // Only two reference clocks are offered, never a synthesizer use.
  // Odd start offsets keep the edges away from the sampling clock edge.
  initial begin
    primary_ref_clock = 1'b0;
    #37;
    forever begin
      #(half_a * 100) primary_ref_clock = ~primary_ref_clock;
    end
  end
  initial begin
    secondary_ref_clock = 1'b0;
    #61;
    forever begin
      #(half_b * 100) secondary_ref_clock = ~secondary_ref_clock;
    end
  end
endmodule

/* tb/phase_matched_divider_tb.sv */
/*
  Self-checking bench of the phase-matched divider: register access over
  AXI4-Lite, output ordering, division, hold and reset. Assumes the
  divider package and the reference clock source model.
*/
`timescale 1ns/10ps
module phase_matched_divider_tb;
  logic ref_clk, rst_n, unhold;
  logic [3:0] half_a, half_b;
  logic pri, sec, o0, o1, o2, o3, o4;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, p_pri, p_sec;
  logic [4:0] prv;
  logic [33:0] q[$];
  logic [31:0] seed, st_exp;
  int failures, comparisons, k, c_pri, c_sec, c_o0, c_o1;
  bit o_chk, h_chk;
  wire [4:0] outs = {o4, o3, o2, o1, o0};

  phase_matched_divider i_phase_matched_divider (
    .ref_clk(ref_clk), .rst_n(rst_n), .primary_ref_clock(pri),
    .secondary_ref_clock(sec), .output_unhold_input(unhold),
    .output_zero(o0), .output_one(o1), .output_two(o2),
    .output_three(o3), .output_four(o4),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ref_clock_source i_ref_clock_source (
    .half_a(half_a), .half_b(half_b),
    .primary_ref_clock(pri), .secondary_ref_clock(sec));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic close_out();
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: bus %h, want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_clk(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: clocks %b, want %b", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: clock count off", $time);
    end
  endtask

  // Each task waits one edge first so no signal is driven twice at once.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] e);
    logic ap, wp, bp;
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    @(posedge ref_clk);
    q.push_back({e, 32'h0000_0000});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bp) begin
      @(posedge ref_clk);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bp = 1'b0;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
    logic ap, rp;
    ap = 1'b1;
    rp = 1'b1;
    @(posedge ref_clk);
    q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rp) begin
      @(posedge ref_clk);
      if (ap && arready) begin
        ap = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rp = 1'b0;
        rready <= 1'b0;
      end
    end
  endtask

  // Latency of a few cycles makes the counts differ by one at most.
  task automatic run_window();
    repeat (40) @(posedge ref_clk);
    #1;
    c_pri = 0;
    c_sec = 0;
    c_o0 = 0;
    c_o1 = 0;
    repeat (300) @(posedge ref_clk);
    cmp_flag(c_o1 - c_pri inside {[-1:1]} && c_pri > 10);
    cmp_flag(c_o0 - c_sec inside {[-1:1]} && c_sec > 10);
  endtask

  always @(posedge ref_clk) begin
    if (bvalid && bready) cmp_bus({bresp, 32'h0000_0000}, q.pop_front());
    if (rvalid && rready) cmp_bus({rresp, rdata}, q.pop_front());
    if (h_chk) cmp_clk(outs & 5'h1E, 5'h00);
    if (o_chk && o1 && !prv[1]) begin
      cmp_clk((outs & ~prv) & 5'h1C, {k[2:0] == 3'h0, k[1:0] == 2'h0,
              k[0] == 1'b0, 2'h0});
      k++;
    end else if (o_chk) begin
      cmp_clk((outs ^ prv) & 5'h1C, 5'h00);
    end
    c_pri += (pri && !p_pri);
    c_sec += (sec && !p_sec);
    c_o1 += (o1 && !prv[1]);
    c_o0 += (o0 && !prv[0]);
    prv = outs;
    p_pri = pri;
    p_sec = sec;
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    unhold = 1'b0;
    half_a = 4'h4;
    half_b = 4'h6;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    seed = 32'hCD8E;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    cmp_clk(outs, 5'h00);
    axi_read(divider_pkg::CTRL_OFFSET, {divider_pkg::RESP_OKAY, 32'h0});
    axi_read(8'h08, {divider_pkg::RESP_SLVERR, 32'h0});
    // Status is read-only and shows only the idle phase count while off.
    st_exp = 32'h0000_0000;
    st_exp[divider_pkg::STAT_CNT_LSB +: 3] = divider_pkg::PHASE_RESET;
    axi_write(divider_pkg::STATUS_OFFSET, 32'hFFFF_FFFF,
              divider_pkg::RESP_OKAY);
    axi_read(divider_pkg::STATUS_OFFSET, {divider_pkg::RESP_OKAY, st_exp});
    // A write without the low byte strobe must leave control untouched.
    wstrb <= 4'hE;
    axi_write(divider_pkg::CTRL_OFFSET, 32'h0000_0007,
              divider_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(divider_pkg::CTRL_OFFSET, {divider_pkg::RESP_OKAY, 32'h0});
    axi_write(8'h0C, 32'h0000_0001, divider_pkg::RESP_SLVERR);
    seed = xs(seed);
    k = 0;
    o_chk = 1'b1;
    axi_write(divider_pkg::CTRL_OFFSET, {seed[31:3], 3'h1},
              divider_pkg::RESP_OKAY);
    axi_read(divider_pkg::CTRL_OFFSET, {divider_pkg::RESP_OKAY, 32'h1});
    run_window();
    o_chk = 1'b0;
    axi_write(divider_pkg::CTRL_OFFSET, 32'h0, divider_pkg::RESP_OKAY);
    repeat (5) @(posedge ref_clk);
    cmp_clk(outs, 5'h00);
    k = 0;
    axi_write(divider_pkg::CTRL_OFFSET, 32'h3, divider_pkg::RESP_OKAY);
    h_chk = 1'b1;
    c_o0 = 0;
    repeat (100) @(posedge ref_clk);
    cmp_flag(c_o0 > 3);
    h_chk = 1'b0;
    o_chk = 1'b1;
    unhold <= 1'b1;
    repeat (60) @(posedge ref_clk);
    cmp_flag(k > 1);
    seed = xs(seed);
    half_a <= 4'h4 + seed[1:0];
    half_b <= 4'h4 + seed[3:2];
    o_chk = 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
    end while (o1 !== 1'b1);
    #20 rst_n = 1'b0;
    #1 cmp_clk(outs, 5'h00);
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) begin
      @(posedge ref_clk);
      #1 cmp_clk(outs, 5'h00);
    end
    k = 0;
    o_chk = 1'b1;
    axi_write(divider_pkg::CTRL_OFFSET, 32'h5, divider_pkg::RESP_OKAY);
    run_window();
    close_out();
  end
endmodule
